// *** hdl/eas_sequencer.sv ***
/*
 * event/action sequencer of a motor drive with start/stop input handling.
 * assumes settings come from same-clock logic; pins are asynchronous.
 */
// Notes on behaviour
// - event N pairs only with action N
// - true event runs action and advances pair on the same clock edge
// - only the current pair's event is tested
// - false event: nothing happens, retry next scan
// - start begins at pair one
// - pair count programmable from zero to twenty
// - after last pair wrap to pair one
// - event codes false, true, on-ref, timeout
// - action codes none, preset0, preset1, timer
// - timer0 loads duration, expiry is an event
// - runs only while enable setting on
// - stop ramps down then goes free
// - input function codes nop, stop, start, latched
`timescale 1ns/1ns
`default_nettype none
module eas_sequencer (
    // clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 reset,
    // settings
    input  wire logic                                 sequencer_enable_setting,
    input  wire logic [eas_pkg::IDX_W-1:0]            pair_count,
    input  wire logic [eas_pkg::MAX_PAIRS*8-1:0]      sequencer_event_select,
    input  wire logic [eas_pkg::MAX_PAIRS*8-1:0]      sequencer_action_select,
    input  wire logic [eas_pkg::TIMER_W-1:0]          sequencer_timer_duration,
    input  wire logic [3:0]                           start_pin_function,
    input  wire logic [3:0]                           stop_pin_function,
    // pins and drive status
    input  wire logic                                 start_pin,
    input  wire logic                                 stop_pin,
    input  wire logic                                 at_reference,
    input  wire logic                                 ramp_done,
    // outputs
    output logic [eas_pkg::IDX_W-1:0]                 current_pair,
    output logic [eas_pkg::PRESET_W-1:0]              preset_select,
    output logic                                      action_strobe,
    output logic                                      motor_run,
    output logic                                      ramp_down,
    output logic                                      motor_free
);
    // pin synchronisers
    logic [1:0] start_sync;
    logic [1:0] stop_sync;
    logic [1:0] ref_sync;
    always_ff @(posedge clk) begin
        if (reset) begin
            start_sync <= 2'h0;
            stop_sync  <= '1;   // stop pin idles high: no false stop
            ref_sync   <= 2'h0;
        end else begin
            start_sync <= {start_sync[0], start_pin};
            stop_sync  <= {stop_sync[0], stop_pin};
            ref_sync   <= {ref_sync[0], at_reference};
        end
    end
    wire start_s = start_sync[1];
    wire stop_s  = stop_sync[1];
    wire ref_s   = ref_sync[1];

    // scan interval strobe
    logic [eas_pkg::SCAN_W-1:0] scan_cnt;
    wire scan_end = (scan_cnt == eas_pkg::SCAN_W'(eas_pkg::SCAN_CYCLES - 1));
    logic scan_tick;
    always_ff @(posedge clk) begin
        if (reset) begin
            scan_cnt  <= '0;
            scan_tick <= 1'b0;
        end else begin
            scan_cnt  <= scan_end ? '0 : scan_cnt + 12'h001;
            scan_tick <= scan_end;
        end
    end

    // select the current pair's codes through one generate loop
    logic [7:0] ev_tab  [eas_pkg::MAX_PAIRS];
    logic [7:0] act_tab [eas_pkg::MAX_PAIRS];
    genvar g;
    generate
        for (g = 0; g < eas_pkg::MAX_PAIRS; g++) begin : g_tab
            assign ev_tab[g]  = sequencer_event_select[g*8 +: 8];
            assign act_tab[g] = sequencer_action_select[g*8 +: 8];
        end
    endgenerate
    wire        idx_ok    = current_pair < eas_pkg::IDX_W'(eas_pkg::MAX_PAIRS);
    wire [7:0]  cur_event = idx_ok ? ev_tab[current_pair]
                                   : eas_pkg::EV_FALSE;
    wire [7:0]  cur_act   = idx_ok ? act_tab[current_pair]
                                   : eas_pkg::ACT_NONE;

    // event decode
    logic timer_expired;
    wire event_true = (cur_event == eas_pkg::EV_TRUE) ||
                      (cur_event == eas_pkg::EV_ON_REF && ref_s) ||
                      (cur_event == eas_pkg::EV_TIMEOUT0 && timer_expired);
    // EV_FALSE and unknown codes fall through as false

    // pair count clipped to twenty
    wire [4:0] count_eff = (pair_count > eas_pkg::IDX_W'(eas_pkg::MAX_PAIRS))
                         ? eas_pkg::IDX_W'(eas_pkg::MAX_PAIRS) : pair_count;
    wire active = sequencer_enable_setting &&
                  (count_eff != 5'h00);
    wire step   = active && scan_tick && event_true;
    wire last   = (current_pair + 5'h01) >= count_eff;
    wire [4:0] next_pair = last ? eas_pkg::IDX_FIRST
                                : current_pair + 5'h01;

    // action decode
    wire do_p0    = step && (cur_act == eas_pkg::ACT_PRESET0);
    wire do_p1    = step && (cur_act == eas_pkg::ACT_PRESET1);
    wire do_timer = step && (cur_act == eas_pkg::ACT_TIMER0);

    // pair pointer and action outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            current_pair  <= eas_pkg::IDX_FIRST;
            preset_select <= eas_pkg::PRESET_RST;
            action_strobe <= 1'b0;
        end else begin
            action_strobe <= step;
            if (!sequencer_enable_setting)
                current_pair <= eas_pkg::IDX_FIRST;
            else if (step)
                current_pair <= next_pair;
            if (do_p0)
                preset_select <= 2'h0;
            else if (do_p1)
                preset_select <= 2'h1;
        end
    end

    eas_timer0 u_timer0 (
        .clk      (clk),
        .reset    (reset),
        .start    (do_timer),
        .duration (sequencer_timer_duration),
        .tick     (scan_tick),
        .expired  (timer_expired)
    );

    // start/stop input functions
    wire stop_req = (stop_pin_function == eas_pkg::DIN_STOP_INV) &&
                    !stop_s;
    logic start_latch;
    wire start_req = (start_pin_function == eas_pkg::DIN_START) ? start_s :
                     (start_pin_function == eas_pkg::DIN_LATCH_START)
                     ? (start_s || start_latch) : 1'b0;
    always_ff @(posedge clk) begin
        if (reset)
            start_latch <= 1'b0;
        else if (stop_req)
            start_latch <= 1'b0;
        else if (start_s)
            start_latch <= 1'b1;
    end

    // motor state: ramp down on stop, then free
    eas_pkg::eas_motor_t mstate;
    eas_pkg::eas_motor_t next_mstate;
    wire run_cmd = start_req && !stop_req;
    always_comb begin
        next_mstate = mstate;
        case (mstate)
            eas_pkg::EAS_FREE:
                if (run_cmd) next_mstate = eas_pkg::EAS_RAMP_UP;
            eas_pkg::EAS_RAMP_UP:
                if (!run_cmd) next_mstate = eas_pkg::EAS_RAMP_DOWN;
                else if (ramp_done) next_mstate = eas_pkg::EAS_RUN;
            eas_pkg::EAS_RUN:
                if (!run_cmd) next_mstate = eas_pkg::EAS_RAMP_DOWN;
            eas_pkg::EAS_RAMP_DOWN:
                if (ramp_done) next_mstate = eas_pkg::EAS_FREE;
            default: next_mstate = eas_pkg::EAS_FREE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            mstate     <= eas_pkg::EAS_FREE;
            motor_run  <= 1'b0;
            ramp_down  <= 1'b0;
            motor_free <= 1'b1;
        end else begin
            mstate     <= next_mstate;
            motor_run  <= next_mstate == eas_pkg::EAS_RAMP_UP ||
                          next_mstate == eas_pkg::EAS_RUN;
            ramp_down  <= next_mstate == eas_pkg::EAS_RAMP_DOWN;
            motor_free <= next_mstate == eas_pkg::EAS_FREE;
        end
    end

    // checks
    hold_false_a: assert property (@(posedge clk) disable iff (reset)
        sequencer_enable_setting && !step |=> $stable(current_pair))
        else $error("pointer moved without a true event");
    step_adv_a: assert property (@(posedge clk) disable iff (reset)
        step && !last && sequencer_enable_setting |=>
        current_pair == $past(current_pair) + 5'h01)
        else $error("pointer did not advance");
    wrap_first_a: assert property (@(posedge clk) disable iff (reset)
        step && last |=> current_pair == 5'h00)
        else $error("no wrap after last pair");
    disable_reset_a: assert property (@(posedge clk) disable iff (reset)
        !sequencer_enable_setting |=> current_pair == 5'h00 && !action_strobe)
        else $error("disabled sequencer not at pair one");
    scan_only_a: assert property (@(posedge clk) disable iff (reset)
        action_strobe |-> $past(scan_tick))
        else $error("action outside scan strobe");
    zero_idle_a: assert property (@(posedge clk) disable iff (reset)
        pair_count == 5'h00 |=> !action_strobe)
        else $error("action with zero pairs");
    preset_set_a: assert property (@(posedge clk) disable iff (reset)
        do_p1 |=> preset_select == 2'h1)
        else $error("preset 1 not selected");
    stop_ramp_a: assert property (@(posedge clk) disable iff (reset)
        mstate == eas_pkg::EAS_RUN && stop_req |=> ramp_down)
        else $error("stop did not ramp down");
    cov_wrap_c: cover property (@(posedge clk) step && last);
    cov_timer_c: cover property (@(posedge clk) do_timer);
    cov_free_c: cover property (@(posedge clk)
        ramp_down ##1 motor_free);
endmodule // eas_sequencer
`default_nettype wire

// *** common/eas_pkg.sv ***
/*
 * constants for the event/action sequencer: selector codes, table size,
 * scan timing and input function codes.
 * assumes a 10 MHz system clock.
 */
`default_nettype none
package eas_pkg;
    localparam int          MAX_PAIRS      = 20;
    localparam int          IDX_W          = 5;
    localparam int          SEL_W          = 8;
    localparam int          TIMER_W        = 24;
    localparam int          PRESET_W       = 2;
    // scan interval and clock rate
    localparam int          CLK_HZ         = 10_000_000;
    localparam int          SCAN_US        = 100;
    localparam int          SCAN_CYCLES    = SCAN_US * (CLK_HZ / 1_000_000);
    localparam int          SCAN_W         = 12;
    // event selector encodings
    localparam logic [7:0]  EV_FALSE       = 8'h00;
    localparam logic [7:0]  EV_TRUE        = 8'h01;
    localparam logic [7:0]  EV_ON_REF      = 8'h04;
    localparam logic [7:0]  EV_TIMEOUT0    = 8'h1e;
    // action selector encodings
    localparam logic [7:0]  ACT_NONE       = 8'h01;
    localparam logic [7:0]  ACT_PRESET0    = 8'h0a;
    localparam logic [7:0]  ACT_PRESET1    = 8'h0b;
    localparam logic [7:0]  ACT_TIMER0     = 8'h1d;
    // digital input function encodings
    localparam logic [3:0]  DIN_NOP        = 4'h0;
    localparam logic [3:0]  DIN_STOP_INV   = 4'h6;
    localparam logic [3:0]  DIN_START      = 4'h8;
    localparam logic [3:0]  DIN_LATCH_START = 4'h9;
    // reset values
    localparam logic [4:0]  IDX_FIRST      = 5'h00;
    localparam logic [1:0]  PRESET_RST     = 2'h0;
    typedef enum logic [1:0] {EAS_FREE, EAS_RAMP_UP, EAS_RUN,
                              EAS_RAMP_DOWN} eas_motor_t;
endpackage
`default_nettype wire

// *** hdl/eas_timer0.sv ***
/*
 * timer 0: loads its duration on start and flags expiry until restarted.
 * assumes start comes from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module eas_timer0 (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    // control
    input  wire logic                          start,
    input  wire logic [eas_pkg::TIMER_W-1:0]   duration,
    input  wire logic                          tick,
    // status
    output logic                               expired
);
    logic [eas_pkg::TIMER_W-1:0] count;
    logic                        running;
    wire                         last_tick = running && tick &&
                                             (count <= 24'h000001);

    // load on start, count scan ticks down, flag at zero
    always_ff @(posedge clk) begin
        if (reset) begin
            count   <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else if (start) begin
            count   <= duration;
            running <= 1'b1;
            expired <= 1'b0;
        end else if (last_tick) begin
            count   <= '0;
            running <= 1'b0;
            expired <= 1'b1;
        end else if (running && tick) begin
            count   <= count - 24'h000001;
        end
    end

    timer_load_a: assert property (@(posedge clk) disable iff (reset)
        start |=> running && !expired)
        else $error("timer did not load on start");
endmodule // eas_timer0
`default_nettype wire

// *** testbench/tb_top.sv ***
/*
 * self-checking bench for the event/action sequencer: program steps,
 * timer, wrap, enable and start/stop handling.
 * assumes a 100 ns clock and inputs driven at the falling edge.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
    bad_count++; $display("CHECK FAILED at %0t ns: got %0h want %0h", \
    $time, got, exp); end end
module tb_top;
    logic         clk = 1'b0;
    logic         reset = 1'b1;
    logic         en = 1'b0;
    logic [4:0]   pair_count = 5'h00;
    logic [159:0] ev = '0;
    logic [159:0] act = '0;
    logic [23:0]  dur = 24'h000002;
    logic [3:0]   start_fn = eas_pkg::DIN_START;
    logic [3:0]   stop_fn = eas_pkg::DIN_STOP_INV;
    logic         start_pin = 1'b0;
    logic         stop_pin = 1'b1;
    logic         at_ref = 1'b0;
    logic         ramp_done = 1'b0;
    logic [4:0]   current_pair;
    logic [1:0]   preset_select;
    logic         action_strobe;
    logic         motor_run;
    logic         ramp_down;
    logic         motor_free;
    int           bad_count = 0;
    int           checks = 0;
    bit           s;

    // clock at 10 MHz
    always #50 clk = ~clk;

    eas_sequencer dut_u (
        .clk(clk), .reset(reset), .sequencer_enable_setting(en),
        .pair_count(pair_count), .sequencer_event_select(ev),
        .sequencer_action_select(act), .sequencer_timer_duration(dur),
        .start_pin_function(start_fn), .stop_pin_function(stop_fn),
        .start_pin(start_pin), .stop_pin(stop_pin), .at_reference(at_ref),
        .ramp_done(ramp_done), .current_pair(current_pair),
        .preset_select(preset_select), .action_strobe(action_strobe),
        .motor_run(motor_run), .ramp_down(ramp_down),
        .motor_free(motor_free));

    // bounded wait for an action dispatch, sampled after the edge
    task automatic wait_strobe(input int lim, output bit seen);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge clk);
            #1;
            if (action_strobe === 1'b1) seen = 1'b1;
        end
        @(negedge clk);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one cycle of ramp finished, then settle
    task automatic pulse_done();
        ramp_done = 1'b1;
        cycles(1);
        ramp_done = 1'b0;
        cycles(4);
    endtask

    task automatic print_verdict();
        $display("counts: %0d checks, %0d mismatches", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        #5_000_000;
        bad_count++;
        $display("CHECK FAILED at %0t ns: watchdog ran out", $time);
        print_verdict();
    end

    initial begin
        cycles(2);
        `CHK(current_pair, 5'h00)
        `CHK(motor_free, 1'b1)
        reset = 1'b0;
        // four pairs: true, on-ref, timeout, false
        ev[7:0] = eas_pkg::EV_TRUE;
        ev[15:8] = eas_pkg::EV_ON_REF;
        ev[23:16] = eas_pkg::EV_TIMEOUT0;
        ev[31:24] = eas_pkg::EV_FALSE;
        act[7:0] = eas_pkg::ACT_PRESET0;
        act[15:8] = eas_pkg::ACT_TIMER0;
        act[23:16] = eas_pkg::ACT_PRESET1;
        act[31:24] = eas_pkg::ACT_NONE;
        pair_count = 5'h04;
        en = 1'b1;
        wait_strobe(1100, s);
        `CHK(s, 1'b1)
        `CHK(current_pair, 5'h01)
        cycles(1);
        `CHK(action_strobe, 1'b0)
        wait_strobe(2100, s);
        `CHK(s, 1'b0)
        `CHK(current_pair, 5'h01)
        at_ref = 1'b1;
        wait_strobe(1100, s);
        `CHK(s, 1'b1)
        `CHK(current_pair, 5'h02)
        at_ref = 1'b0;
        wait_strobe(1500, s);
        `CHK(s, 1'b0)
        wait_strobe(2600, s);
        `CHK(s, 1'b1)
        `CHK(current_pair, 5'h03)
        `CHK(preset_select, 2'h1)
        wait_strobe(1100, s);
        `CHK(s, 1'b0)
        ev[31:24] = eas_pkg::EV_TRUE;
        wait_strobe(1100, s);
        `CHK(s, 1'b1)
        `CHK(current_pair, 5'h00)
        `CHK(preset_select, 2'h1)
        wait_strobe(1100, s);
        `CHK(preset_select, 2'h0)
        `CHK(current_pair, 5'h01)
        en = 1'b0;
        cycles(2);
        `CHK(current_pair, 5'h00)
        wait_strobe(2100, s);
        `CHK(s, 1'b0)
        pair_count = 5'h00;
        en = 1'b1;
        wait_strobe(2100, s);
        `CHK(s, 1'b0)
        pair_count = 5'h01;
        wait_strobe(1100, s);
        `CHK(s, 1'b1)
        `CHK(current_pair, 5'h00)
        $display("test done: sequencer");
        // level start, inverted stop, ramp down to free
        start_pin = 1'b1;
        cycles(6);
        `CHK(motor_run, 1'b1)
        pulse_done();
        `CHK(motor_run, 1'b1)
        stop_pin = 1'b0;
        cycles(6);
        `CHK(ramp_down, 1'b1)
        `CHK(motor_free, 1'b0)
        pulse_done();
        `CHK(motor_free, 1'b1)
        start_pin = 1'b0;
        stop_pin = 1'b1;
        cycles(6);
        // latched start held after the pin drops, cleared by stop
        start_fn = eas_pkg::DIN_LATCH_START;
        start_pin = 1'b1;
        cycles(4);
        start_pin = 1'b0;
        cycles(6);
        `CHK(motor_run, 1'b1)
        stop_pin = 1'b0;
        cycles(6);
        pulse_done();
        stop_pin = 1'b1;
        cycles(6);
        `CHK(motor_free, 1'b1)
        start_fn = eas_pkg::DIN_NOP;
        start_pin = 1'b1;
        cycles(6);
        `CHK(motor_free, 1'b1)
        $display("test done: start and stop");
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
